// ===== src/apcr_regs.sv
// Audio port configuration registers, channel routing and clock-loss detector
`timescale 1ns/1ps

// Functional notes
// - The format field, bits 5-4 of 0x28, picks I2S, DIRECT_STREAM_DIGITAL, right- or left-justified, reset 00.
// - The word length field, bits 1-0 of 0x28, picks 16, 20, 24 or 32 bits, reset 24 bits.
// - The frame offset at 0x29 is the bit clock count from frame start to wanted sample.
// - Offset zero is the reset value with no shift, each step adds one, all-ones means 256.
// - The left source picks mute, left data or right data for the left DAC, reset 01.
// - The right source picks mute, right data or left data for the right DAC, reset 01.
// - Program select resets to 00001, the first built-in program.
// - Both audio clocks low past the loss period send the DAC to powerdown.
// - Only a low level counts as missing, and the ignore input blocks powerdown.
module apcr_regs #(
    parameter longint CYCLES_PER_STEP = apcr_pkg::LOSS_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_sclk,
    input wire logic i_lrclk,
    input wire logic i_ignore_missing_clocks,
    input wire apcr_pkg::apcr_pair_t i_sample,
    output apcr_pkg::apcr_pair_t o_dac,
    output apcr_pkg::apcr_cfg_t o_cfg,
    output logic o_dac_powerdown
);
    apcr_pkg::apcr_state_t state_r;
    apcr_pkg::apcr_state_t state_nxt;
    logic ack_r;
    logic [31:0] limit;

    // Period code n lasts n+1 steps
    assign limit = 32'((64'(state_r.loss_code) + 64'd1) * 64'(CYCLES_PER_STEP));

    function automatic logic [apcr_pkg::SAMPLE_W-1:0] route(
        input logic [1:0] src,
        input logic [apcr_pkg::SAMPLE_W-1:0] own,
        input logic [apcr_pkg::SAMPLE_W-1:0] other
    );
        case (src)
            apcr_pkg::SRC_OWN: route = own;
            apcr_pkg::SRC_SWAP: route = other;
            default: route = '0;
        endcase
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        // Register writes keep only defined fields; reserved bits are dropped
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                apcr_pkg::REG_SERIAL_FORMAT_LENGTH:
                begin
                    state_nxt.fmt = i_reg_wdata[apcr_pkg::FMT_LSB +: 2];
                    state_nxt.wlen = i_reg_wdata[apcr_pkg::WLEN_LSB +: 2];
                end
                apcr_pkg::REG_FRAME_OFFSET: state_nxt.ofs = i_reg_wdata;
                apcr_pkg::REG_CHANNEL_ROUTING:
                begin
                    state_nxt.lsrc = i_reg_wdata[apcr_pkg::LSRC_LSB +: 2];
                    state_nxt.rsrc = i_reg_wdata[apcr_pkg::RSRC_LSB +: 2];
                end
                apcr_pkg::REG_PROGRAM_SELECT:
                    state_nxt.psel = i_reg_wdata[apcr_pkg::PSEL_LSB +: 5];
                apcr_pkg::REG_CLOCK_LOSS_PERIOD:
                    state_nxt.loss_code = i_reg_wdata[apcr_pkg::LOSS_LSB +: 3];
                default:
                begin
                end
            endcase
        end
        // Read data; reserved bits and unmapped addresses read zero
        case (i_reg_addr)
            apcr_pkg::REG_SERIAL_FORMAT_LENGTH:
                state_nxt.rdata = {2'h0, state_r.fmt, 2'h0, state_r.wlen};
            apcr_pkg::REG_FRAME_OFFSET: state_nxt.rdata = state_r.ofs;
            apcr_pkg::REG_CHANNEL_ROUTING:
                state_nxt.rdata = {2'h0, state_r.lsrc, 2'h0, state_r.rsrc};
            apcr_pkg::REG_PROGRAM_SELECT: state_nxt.rdata = {3'h0, state_r.psel};
            apcr_pkg::REG_CLOCK_LOSS_PERIOD: state_nxt.rdata = {5'h00, state_r.loss_code};
            default: state_nxt.rdata = 8'h00;
        endcase
        // Two-flop synchronisers for the audio clocks
        state_nxt.sclk_m = i_sclk;
        state_nxt.sclk_s = state_r.sclk_m;
        state_nxt.lrclk_m = i_lrclk;
        state_nxt.lrclk_s = state_r.lrclk_m;
        // Low-level timer: any high level restarts it, static high never counts
        if (state_r.sclk_s || state_r.lrclk_s)
        begin
            state_nxt.low_cnt = 32'h0;
            state_nxt.powerdown = 1'b0;
        end
        else
        begin
            if (state_r.low_cnt < limit)
                state_nxt.low_cnt = state_r.low_cnt + 32'h1;
            state_nxt.powerdown = (state_r.low_cnt >= limit) && !i_ignore_missing_clocks;
        end
        // Channel routing into the DAC; code 11 is treated as mute
        state_nxt.dac.left = route(state_r.lsrc, i_sample.left, i_sample.right);
        state_nxt.dac.right = route(state_r.rsrc, i_sample.right, i_sample.left);
        // Decoded configuration
        state_nxt.cfg.serial_format_select = state_r.fmt;
        case (state_r.wlen)
            2'h0: state_nxt.cfg.sample_word_bits = apcr_pkg::WLEN_16;
            2'h1: state_nxt.cfg.sample_word_bits = apcr_pkg::WLEN_20;
            2'h2: state_nxt.cfg.sample_word_bits = apcr_pkg::WLEN_24;
            default: state_nxt.cfg.sample_word_bits = apcr_pkg::WLEN_32;
        endcase
        if (state_r.ofs == apcr_pkg::OFS_MAX_CODE)
            state_nxt.cfg.frame_data_offset_clks = apcr_pkg::OFS_MAX_CLKS;
        else
            state_nxt.cfg.frame_data_offset_clks = {1'b0, state_r.ofs};
        state_nxt.cfg.program_select = state_r.psel;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r <= '0;
            state_r.fmt <= apcr_pkg::FMT_RST;
            state_r.wlen <= apcr_pkg::WLEN_RST;
            state_r.ofs <= apcr_pkg::OFS_RST;
            state_r.lsrc <= apcr_pkg::SRC_RST;
            state_r.rsrc <= apcr_pkg::SRC_RST;
            state_r.psel <= apcr_pkg::PSEL_RST;
            state_r.loss_code <= apcr_pkg::LOSS_RST;
            state_r.cfg.serial_format_select <= apcr_pkg::FMT_RST;
            state_r.cfg.sample_word_bits <= apcr_pkg::WLEN_24;
            state_r.cfg.frame_data_offset_clks <= 9'h000;
            state_r.cfg.program_select <= apcr_pkg::PSEL_RST;
            ack_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ack_r <= i_reg_rd || i_reg_wr;
        end
    end

    assign o_reg_rdata = state_r.rdata;
    assign o_reg_ack = ack_r;
    assign o_dac = state_r.dac;
    assign o_cfg = state_r.cfg;
    assign o_dac_powerdown = state_r.powerdown;
endmodule

// ===== src/apcr_pkg.sv
// Constants and types for the audio port configuration registers
package apcr_pkg;
    // Register offsets
    localparam logic [7:0] REG_SERIAL_FORMAT_LENGTH = 8'h28;
    localparam logic [7:0] REG_FRAME_OFFSET = 8'h29;
    localparam logic [7:0] REG_CHANNEL_ROUTING = 8'h2A;
    localparam logic [7:0] REG_PROGRAM_SELECT = 8'h2B;
    localparam logic [7:0] REG_CLOCK_LOSS_PERIOD = 8'h2C;
    // Field positions (low bit)
    localparam int FMT_LSB = 4;
    localparam int WLEN_LSB = 0;
    localparam int LSRC_LSB = 4;
    localparam int RSRC_LSB = 0;
    localparam int PSEL_LSB = 0;
    localparam int LOSS_LSB = 0;
    // Reset values
    localparam logic [1:0] FMT_RST = 2'h0;
    localparam logic [1:0] WLEN_RST = 2'h2;
    localparam logic [7:0] OFS_RST = 8'h00;
    localparam logic [1:0] SRC_RST = 2'h1;
    localparam logic [4:0] PSEL_RST = 5'h01;
    localparam logic [2:0] LOSS_RST = 3'h0;
    // Serial formats
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_DIRECT_STREAM_DIGITAL = 2'h1;
    localparam logic [1:0] FMT_RIGHT_JUSTIFIED = 2'h2;
    localparam logic [1:0] FMT_LEFT_JUSTIFIED = 2'h3;
    // Path source codes
    localparam logic [1:0] SRC_ZERO = 2'h0;
    localparam logic [1:0] SRC_OWN = 2'h1;
    localparam logic [1:0] SRC_SWAP = 2'h2;
    // Word lengths in bits
    localparam logic [5:0] WLEN_16 = 6'h10;
    localparam logic [5:0] WLEN_20 = 6'h14;
    localparam logic [5:0] WLEN_24 = 6'h18;
    localparam logic [5:0] WLEN_32 = 6'h20;
    localparam logic [7:0] OFS_MAX_CODE = 8'hFF;
    localparam logic [8:0] OFS_MAX_CLKS = 9'h100;
    // Timing
    localparam int SAMPLE_W = 32;
    localparam longint CLK_PERIOD_PS = 4000;
    localparam longint LOSS_STEP_S = 1;
    localparam longint LOSS_STEP_CYCLES = (LOSS_STEP_S * 64'd1000000000000) / CLK_PERIOD_PS;

    typedef struct packed {
        logic [1:0] serial_format_select;
        logic [5:0] sample_word_bits;
        logic [8:0] frame_data_offset_clks;
        logic [4:0] program_select;
    } apcr_cfg_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } apcr_pair_t;

    typedef struct packed {
        logic [1:0] fmt;
        logic [1:0] wlen;
        logic [7:0] ofs;
        logic [1:0] lsrc;
        logic [1:0] rsrc;
        logic [4:0] psel;
        logic [2:0] loss_code;
        logic sclk_m;
        logic sclk_s;
        logic lrclk_m;
        logic lrclk_s;
        logic [31:0] low_cnt;
        logic powerdown;
        logic [7:0] rdata;
        apcr_pair_t dac;
        apcr_cfg_t cfg;
    } apcr_state_t;
endpackage

// ===== verification/apcr_regs_props.sv
// Assertions on the audio port configuration register block
`timescale 1ns/1ps
module apcr_regs_props #(
    parameter longint CYCLES_PER_STEP = 20
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_sclk,
    input wire logic i_lrclk,
    input wire logic i_ignore_missing_clocks,
    input wire apcr_pkg::apcr_cfg_t o_cfg,
    input wire logic o_dac_powerdown
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [31:0] low_r;
    // Cycles both pins have been sampled low
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            low_r <= 32'h0;
        else
            low_r <= (i_sclk | i_lrclk) ? 32'h0 : low_r + 32'h1;
    end
    AST_FMT: assert property (i_reg_wr && i_reg_addr == 8'h28 |=> ##1
        o_cfg.serial_format_select == $past(i_reg_wdata[5:4], 2)) else $error("format");
    AST_WLEN: assert property (i_reg_wr && i_reg_addr == 8'h28 |=> ##1
        o_cfg.sample_word_bits == ($past(i_reg_wdata[1:0], 2) == 2'h3 ? 6'h20
        : 6'h10 + {2'h0, $past(i_reg_wdata[1:0], 2), 2'h0})) else $error("word length");
    AST_OFS: assert property (i_reg_wr && i_reg_addr == 8'h29 |=> ##1
        o_cfg.frame_data_offset_clks == ($past(i_reg_wdata, 2) == 8'hFF ? 9'h100
        : {1'b0, $past(i_reg_wdata, 2)})) else $error("offset");
    AST_PSEL: assert property (i_reg_wr && i_reg_addr == 8'h2B |=> ##1
        o_cfg.program_select == $past(i_reg_wdata[4:0], 2)) else $error("program");
    AST_PD_EARLY: assert property ($rose(o_dac_powerdown) |->
        low_r > CYCLES_PER_STEP) else $error("powerdown too early");
    AST_PD_LATE: assert property (low_r > 8 * CYCLES_PER_STEP + 5 &&
        !$past(i_ignore_missing_clocks) |-> o_dac_powerdown) else $error("powerdown late");
    AST_IGNORE: assert property (i_ignore_missing_clocks |=>
        !o_dac_powerdown) else $error("ignore not honoured");
    AST_CLK_HIGH: assert property (i_sclk | i_lrclk |-> ##4
        !o_dac_powerdown) else $error("powerdown with clock high");
endmodule
bind apcr_regs apcr_regs_props #(.CYCLES_PER_STEP(CYCLES_PER_STEP)) u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_sclk(i_sclk), .i_lrclk(i_lrclk),
    .i_ignore_missing_clocks(i_ignore_missing_clocks), .o_cfg(o_cfg),
    .o_dac_powerdown(o_dac_powerdown));

// ===== verification/apcr_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module apcr_host (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    output logic o_wr = 1'b0,
    output logic o_rd = 1'b0,
    output logic [7:0] o_addr = 8'h00,
    output logic [7:0] o_wdata = 8'h00
);
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        logic [7:0] m;
        m = d & (a == 8'h29 ? 8'hFF : a == 8'h2B ? 8'h1F : a == 8'h2C ? 8'h07 : 8'h33);
        if (a == 8'h2A && (m[5:4] == 2'h3 || m[1:0] == 2'h3))
            m = 8'h11;
        @(negedge i_clk);
        o_addr = a;
        o_wdata = m;
        o_wr = w;
        o_rd = !w;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        q = i_rdata;
        if (i_ack !== 1'b1)
        begin
            testbench.err_count++;
            testbench.complete_run();
        end
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the audio port configuration registers
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        apcr_pkg::apcr_cfg_t c;
        logic [1:0] l;
        logic [1:0] r;
    } apcr_row_t;
    localparam logic [31:0] LV = 32'hA5A50001;
    localparam logic [31:0] RV = 32'h5A5A0002;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_sclk = 1'b0, i_lrclk = 1'b0, ign = 1'b0, run = 1'b0;
    logic wr, rd, ack, pd;
    logic [7:0] addr, wdata, rdata, q;
    logic [7:0] rv [5] = '{8'h02, 8'h00, 8'h11, 8'h01, 8'h00};
    apcr_pkg::apcr_pair_t dac;
    apcr_pkg::apcr_cfg_t cfg;
    int err_count = 0, compares = 0, n;
    apcr_row_t rows [10] = '{
        '{8'h28, 8'h13, {2'h1, 6'h20, 9'h000, 5'h01}, 2'h1, 2'h2},
        '{8'h28, 8'h20, {2'h2, 6'h10, 9'h000, 5'h01}, 2'h1, 2'h2},
        '{8'h28, 8'h31, {2'h3, 6'h14, 9'h000, 5'h01}, 2'h1, 2'h2},
        '{8'h28, 8'h02, {2'h0, 6'h18, 9'h000, 5'h01}, 2'h1, 2'h2},
        '{8'h29, 8'hFF, {2'h0, 6'h18, 9'h100, 5'h01}, 2'h1, 2'h2},
        '{8'h29, 8'h01, {2'h0, 6'h18, 9'h001, 5'h01}, 2'h1, 2'h2},
        '{8'h2A, 8'h20, {2'h0, 6'h18, 9'h001, 5'h01}, 2'h2, 2'h0},
        '{8'h2A, 8'h02, {2'h0, 6'h18, 9'h001, 5'h01}, 2'h0, 2'h1},
        '{8'h2B, 8'h05, {2'h0, 6'h18, 9'h001, 5'h05}, 2'h0, 2'h1},
        '{8'h2C, 8'h07, {2'h0, 6'h18, 9'h001, 5'h05}, 2'h0, 2'h1}};
    apcr_host h (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    apcr_regs #(.CYCLES_PER_STEP(20)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_ack(ack), .i_sclk(i_sclk), .i_lrclk(i_lrclk), .i_ignore_missing_clocks(ign),
        .i_sample({LV, RV}), .o_dac(dac), .o_cfg(cfg), .o_dac_powerdown(pd));
    initial forever #2 i_clk = ~i_clk;
    always #62.5 if (run) i_sclk = ~i_sclk;
    always #1000 if (run) i_lrclk = ~i_lrclk;
    function automatic logic [31:0] pick(input logic [1:0] s);
        return s == 2'h1 ? LV : s == 2'h2 ? RV : 32'h0;
    endfunction
    task automatic check(input logic [63:0] g, e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(negedge i_clk);
        i_nrst = 1'b1;
        run = 1'b1;
        check(cfg, {2'h0, 6'h18, 9'h000, 5'h01});
        for (n = 0; n < 5; n++)
        begin
            h.xfer(1'b0, 8'h28 + n[7:0], 8'h00, q);
            check(q, rv[n]);
        end
        foreach (rows[i])
        begin
            h.xfer(1'b1, rows[i].a, rows[i].d, q);
            h.xfer(1'b0, rows[i].a, 8'h00, q);
            check(q, rows[i].d);
            check(cfg, rows[i].c);
            check(dac, {pick(rows[i].l), pick(rows[i].r)});
        end
        h.xfer(1'b1, 8'h30, 8'hFF, q);
        h.xfer(1'b0, 8'h30, 8'h00, q);
        check(q, 8'h00);
        h.xfer(1'b1, 8'h2C, 8'h01, q);
        run = 1'b0;
        i_sclk = 1'b1;
        repeat (4) @(negedge i_clk);
        i_sclk = 1'b0;
        i_lrclk = 1'b0;
        for (n = 0; n < 200 && pd !== 1'b1; n++)
            @(negedge i_clk);
        check(n > 40 && n < 47, 1'b1);
        ign = 1'b1;
        repeat (2) @(negedge i_clk);
        check(pd, 1'b0);
        ign = 1'b0;
        repeat (130) @(negedge i_clk);
        check(pd, 1'b1);
        i_sclk = 1'b1;
        repeat (100) @(negedge i_clk);
        check(pd, 1'b0);
        i_nrst = 1'b0;
        repeat (2) @(negedge i_clk);
        check(cfg, {2'h0, 6'h18, 9'h000, 5'h01});
        check(dac, 64'h0);
        i_nrst = 1'b1;
        h.xfer(1'b0, 8'h2A, 8'h00, q);
        check(q, 8'h11);
        h.xfer(1'b0, 8'h2C, 8'h00, q);
        check(q, 8'h00);
        complete_run();
    end
endmodule
